// file: src/fps_pkg.sv
/*
 Package for the front-panel switch and LED supervisor.
 Holds timing figures, derived cycle counts, fault codes and mode encodings.
 Assumes a single 10 MHz system clock.
*/
`default_nettype none
package fps_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10000000; // System clock rate
    localparam int unsigned HOLD_MS = 3000; // Switch hold time, 3 s
    localparam int unsigned GAP_MS = 2000; // Dark gap after a burst, 2 s
    localparam int unsigned REBOOT_S = 30; // Time allowed for reboot
    localparam int unsigned FLASH_MS = 500; // Half period of 1 Hz flash
    // Derived cycle counts (integer division truncates; exact at 10 MHz)
    localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
    localparam int unsigned GAP_CYC = (CLK_HZ / 1000) * GAP_MS;
    localparam int unsigned REBOOT_CYC = CLK_HZ * REBOOT_S;
    localparam int unsigned FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
    // ------------------------------------------------------------
    // Fault codes: value is the flash count of the burst
    // ------------------------------------------------------------
    localparam logic [2:0] FLT_NONE = 3'h0; // No fault
    localparam logic [2:0] FLT_ID_EMPTY = 3'h2; // Network identifier empty
    localparam logic [2:0] FLT_ID_CORRUPT = 3'h3; // Internal identifier file corrupt
    localparam logic [2:0] FLT_ID_TEXT = 3'h4; // Identifier text file invalid
    localparam logic [2:0] FLT_ID_MISSING = 3'h5; // File missing or card empty
    // ------------------------------------------------------------
    // Load kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FPS_LD_NONE = 2'b00,
        FPS_LD_FW = 2'b01,
        FPS_LD_APP = 2'b10
    } fps_load_t;
    // ------------------------------------------------------------
    // LED sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FPS_ST_BOOT = 3'b000,
        FPS_ST_IDLE = 3'b001,
        FPS_ST_LOAD = 3'b010,
        FPS_ST_FAIL = 3'b011,
        FPS_ST_REBOOT = 3'b100
    } fps_state_t;
endpackage
`default_nettype wire

// file: src/fps_front_panel.sv
/*
 Front-panel supervisor: interprets the load and run/stop switches by hold
 time and power-up state, requests loads, mode toggles and erase, and
 drives the OK and RUN LEDs with status and counted fault bursts.
 Assumes switch inputs are debounced, active high and synchronous to
 ref_clk; card status and load results come from the firmware side.
*/
`timescale 1ns/10ps
`default_nettype none
module fps_front_panel #(
    parameter int unsigned HOLD_CYC = fps_pkg::HOLD_CYC, // Switch hold time
    parameter int unsigned GAP_CYC = fps_pkg::GAP_CYC, // Dark gap length
    parameter int unsigned FLASH_CYC = fps_pkg::FLASH_CYC, // Flash half period
    parameter int unsigned REBOOT_CYC = fps_pkg::REBOOT_CYC // Reboot allowance
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic load_sw,
    input wire logic run_sw,
    input wire logic boot_done,
    input wire logic card_bootable,
    input wire logic card_fw_found,
    input wire logic card_app_found,
    input wire logic self_test_pass,
    input wire logic io_forcing,
    input wire logic dload_active,
    input wire logic dload_done,
    input wire logic dload_fail,
    input wire logic [2:0] dload_err,
    input wire logic [2:0] fault_code,
    output logic card_boot_q,
    output logic fw_load_q,
    output logic app_load_q,
    output logic erase_all_q,
    output logic run_mode_q,
    output logic reboot_q,
    output logic ok_led_q,
    output logic run_led_q
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q; // First release stage
    logic rst_n_q; // Released reset used by all logic
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Saturating increment of a 32-bit counter
    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
    endfunction

    // ------------------------------------------------------------
    // Switch hold timing and actions
    // ------------------------------------------------------------
    logic [31:0] hold_q, hold_d; // Cycles the current combination is held
    logic [1:0] combo_q, combo_d; // Switch combination being timed
    logic fired_q, fired_d; // Action issued; wait for release
    logic strap_q, strap_d; // Power-up strap sampled
    logic card_boot_d, fw_load_d, app_load_d, erase_all_d, run_mode_d;
    logic [1:0] combo; // Live combination {load, run}
    fps_pkg::fps_load_t kind; // Which load the card contents select

    always_comb begin
        combo = {load_sw, run_sw};
        // Firmware first, else application, else nothing
        if (card_fw_found) begin
            kind = fps_pkg::FPS_LD_FW;
        end else if (card_app_found) begin
            kind = fps_pkg::FPS_LD_APP;
        end else begin
            kind = fps_pkg::FPS_LD_NONE;
        end
        hold_d = hold_q;
        combo_d = combo;
        fired_d = fired_q;
        strap_d = 1'b1;
        card_boot_d = card_boot_q;
        fw_load_d = 1'b0;
        app_load_d = 1'b0;
        erase_all_d = 1'b0;
        run_mode_d = run_mode_q;
        // Strap caught once, just after reset release
        if (!strap_q) begin
            card_boot_d = load_sw;
            if (load_sw && card_bootable && card_fw_found) begin
                fw_load_d = 1'b1;
            end
        end
        // Timing restarts whenever the combination changes, so a
        // late second switch does not inherit the first one's time
        if (combo != combo_q || combo == 2'b00) begin
            hold_d = 32'h0;
            fired_d = 1'b0;
        end else begin
            hold_d = sat_inc(hold_q);
        end
        // Fires one edge after hold_q reaches HOLD_CYC - 1, so the
        // combination has stood unchanged for HOLD_CYC full cycles
        // Hold actions only once boot is complete
        if (boot_done && strap_q && !fired_q && combo == combo_q &&
            hold_q == HOLD_CYC - 1) begin
            fired_d = 1'b1;
            case (combo)
                2'b11: erase_all_d = 1'b1;
                2'b01: run_mode_d = !run_mode_q;
                2'b10: begin
                    fw_load_d = (kind == fps_pkg::FPS_LD_FW);
                    app_load_d = (kind == fps_pkg::FPS_LD_APP);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hold_q <= 32'h0;
            combo_q <= 2'b00;
            fired_q <= 1'b0;
            strap_q <= 1'b0;
            card_boot_q <= 1'b0;
            fw_load_q <= 1'b0;
            app_load_q <= 1'b0;
            erase_all_q <= 1'b0;
            run_mode_q <= 1'b0;
        end else if (clk_en) begin
            hold_q <= hold_d;
            combo_q <= combo_d;
            fired_q <= fired_d;
            strap_q <= strap_d;
            card_boot_q <= card_boot_d;
            fw_load_q <= fw_load_d;
            app_load_q <= app_load_d;
            erase_all_q <= erase_all_d;
            run_mode_q <= run_mode_d;
        end
    end

    // ------------------------------------------------------------
    // LED sequencer
    // ------------------------------------------------------------
    fps_pkg::fps_state_t st_q, st_d; // Sequencer state
    logic [31:0] tmr_q, tmr_d; // Phase timer
    logic [2:0] code_q, code_d; // Burst length in flashes
    logic [2:0] cnt_q, cnt_d; // Flashes done in this burst
    logic phase_q, phase_d; // Flash phase, 1 = lit
    logic gap_q, gap_d; // In dark gap after a burst
    logic reboot_d, ok_led_d, run_led_d;
    logic tick; // Half period elapsed

    always_comb begin
        tick = (tmr_q >= FLASH_CYC - 1);
        st_d = st_q;
        tmr_d = sat_inc(tmr_q);
        code_d = code_q;
        cnt_d = cnt_q;
        phase_d = phase_q;
        gap_d = gap_q;
        reboot_d = 1'b0;
        ok_led_d = 1'b0;
        run_led_d = 1'b0;
        case (st_q)
            fps_pkg::FPS_ST_BOOT, fps_pkg::FPS_ST_IDLE: begin
                if (tick) begin
                    tmr_d = 32'h0;
                    phase_d = !phase_q;
                end
                // Normal status display
                if (io_forcing) begin
                    ok_led_d = phase_q;
                end else begin
                    ok_led_d = self_test_pass;
                end
                run_led_d = run_mode_q;
                // Start-up fault bursts take over the display
                if (fault_code >= fps_pkg::FLT_ID_EMPTY &&
                    fault_code <= fps_pkg::FLT_ID_MISSING) begin
                    st_d = fps_pkg::FPS_ST_FAIL;
                    code_d = fault_code;
                    cnt_d = 3'h0;
                    phase_d = 1'b0;
                    gap_d = 1'b0;
                    tmr_d = 32'h0;
                end else if (dload_active) begin
                    st_d = fps_pkg::FPS_ST_LOAD;
                    tmr_d = 32'h0;
                    phase_d = 1'b0;
                end
            end
            fps_pkg::FPS_ST_LOAD: begin
                // OK and RUN in opposite phase
                ok_led_d = phase_q;
                run_led_d = !phase_q;
                if (tick) begin
                    tmr_d = 32'h0;
                    phase_d = !phase_q;
                end
                if (dload_done) begin
                    st_d = fps_pkg::FPS_ST_REBOOT;
                    tmr_d = 32'h0;
                end else if (dload_fail) begin
                    st_d = fps_pkg::FPS_ST_FAIL;
                    code_d = (dload_err == 3'h0) ? 3'h1 : dload_err;
                    cnt_d = 3'h0;
                    phase_d = 1'b0;
                    gap_d = 1'b0;
                    tmr_d = 32'h0;
                end
            end
            fps_pkg::FPS_ST_FAIL: begin
                // Both LEDs together, counted burst then dark gap
                ok_led_d = phase_q && !gap_q;
                run_led_d = phase_q && !gap_q;
                if (gap_q) begin
                    if (tmr_q >= GAP_CYC - 1) begin
                        gap_d = 1'b0;
                        cnt_d = 3'h0;
                        tmr_d = 32'h0;
                    end
                end else if (tick) begin
                    tmr_d = 32'h0;
                    phase_d = !phase_q;
                    if (phase_q) begin
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q + 3'h1 == code_q) begin
                            gap_d = 1'b1;
                        end
                    end
                end
                // A new download restarts the sequence
                if (dload_active && !dload_fail) begin
                    st_d = fps_pkg::FPS_ST_LOAD;
                    tmr_d = 32'h0;
                    phase_d = 1'b0;
                end
            end
            fps_pkg::FPS_ST_REBOOT: begin
                // Flashing stopped; reboot request held for the allowance
                reboot_d = 1'b1;
                if (tmr_q >= REBOOT_CYC - 1) begin
                    st_d = fps_pkg::FPS_ST_BOOT;
                    tmr_d = 32'h0;
                end
            end
            default: st_d = fps_pkg::FPS_ST_BOOT;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= fps_pkg::FPS_ST_BOOT;
            tmr_q <= 32'h0;
            code_q <= 3'h0;
            cnt_q <= 3'h0;
            phase_q <= 1'b0;
            gap_q <= 1'b0;
            reboot_q <= 1'b0;
            ok_led_q <= 1'b0;
            run_led_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            code_q <= code_d;
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            gap_q <= gap_d;
            reboot_q <= reboot_d;
            ok_led_q <= ok_led_d;
            run_led_q <= run_led_d;
        end
    end
endmodule // fps_front_panel
`default_nettype wire

// file: bench/fps_front_panel_properties.sv
/* Port checker for the front-panel supervisor.
   Bound onto fps_front_panel below; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module fps_fp_checker #(
    parameter int unsigned REBOOT_CYC = 50 // Reboot allowance
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic load_sw,
    input wire logic run_sw,
    input wire logic boot_done,
    input wire logic card_fw_found,
    input wire logic dload_active,
    input wire logic fw_load_q,
    input wire logic app_load_q,
    input wire logic erase_all_q,
    input wire logic run_mode_q,
    input wire logic reboot_q,
    input wire logic card_boot_q,
    input wire logic ok_led_q,
    input wire logic run_led_q
);
    // Cycles reboot_q has stood high; too long for a repetition
    logic [31:0] rb_q;
    logic [31:0] rb_d;
    always_comb begin
        rb_d = reboot_q ? rb_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rb_q <= 32'h0;
        end else begin
            rb_q <= rb_d;
        end
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    pulse_single_a: assert property (fw_load_q |=> !fw_load_q)
        else $error("load pulse too long");
    load_excl_a: assert property (!(fw_load_q && app_load_q))
        else $error("two load kinds at once");
    app_no_fw_a: assert property (app_load_q |-> !$past(card_fw_found))
        else $error("application load with firmware present");
    app_hold_a: assert property (app_load_q |-> $past(boot_done) && $past(load_sw, 8))
        else $error("application load without held switch");
    erase_hold_a: assert property (erase_all_q |-> $past(run_sw) && $past(load_sw, 8))
        else $error("erase without both switches");
    mode_hold_a: assert property ($changed(run_mode_q) |-> $past(run_sw, 8) && !$past(load_sw))
        else $error("mode change without run switch");
    strap_keep_a: assert property (card_boot_q |=> card_boot_q)
        else $error("card boot flag lost");
    reboot_dark_a: assert property (reboot_q && $past(reboot_q) |-> !ok_led_q && !run_led_q)
        else $error("led lit during reboot");
    reboot_len_a: assert property ($fell(reboot_q) |-> rb_q == REBOOT_CYC)
        else $error("reboot length wrong");
    load_alt_a: assert property ((dload_active && boot_done) [*3] |-> ok_led_q != run_led_q)
        else $error("leds not alternating in download");
    erase_cv: cover property (erase_all_q);
    app_cv: cover property (app_load_q);
    reboot_cv: cover property ($fell(reboot_q));
endmodule // fps_fp_checker
bind fps_front_panel fps_fp_checker #(.REBOOT_CYC(REBOOT_CYC)) i_fps_fp_checker (
    .ref_clk, .arst_n, .load_sw, .run_sw, .boot_done, .card_fw_found, .dload_active,
    .fw_load_q, .app_load_q, .erase_all_q, .run_mode_q, .reboot_q, .card_boot_q,
    .ok_led_q, .run_led_q
);
`default_nettype wire

// file: bench/fps_card_model.sv
/* Card and loader model at the supervisor's far side.
   Answers each load pulse with a download ending in success or failure. */
`timescale 1ns/10ps
`default_nettype none
module fps_card_model #(
    parameter int LEN = 20 // Download cycles; small is prompt, large slow
) (
    input wire logic ref_clk,
    input wire logic fw_load_q,
    input wire logic app_load_q,
    input wire logic fail_mode,
    input wire logic [2:0] fail_err,
    output logic dload_active = 1'b0,
    output logic dload_done = 1'b0,
    output logic dload_fail = 1'b0,
    output logic [2:0] dload_err
);
    int left = 0; // Transfer cycles still to run
    assign dload_err = fail_err;
    // Result flagged in the last busy cycle, then busy drops
    always @(posedge ref_clk) begin
        dload_done <= 1'b0;
        dload_fail <= 1'b0;
        dload_active <= left > 0;
        if (fw_load_q || app_load_q) begin
            left <= LEN;
        end else if (left > 0) begin
            left <= left - 1;
            dload_done <= left == 1 && !fail_mode;
            dload_fail <= left == 1 && fail_mode;
        end
    end
endmodule // fps_card_model
`default_nettype wire

// file: bench/tb_top.sv
/* Self-checking bench for the front-panel supervisor.
   Counts shortened by parameter; the card side is a model. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int HOLD = 20; // Switch hold cycles
    localparam int GAP = 30; // Dark gap cycles
    localparam int FL = 4; // Flash half period
    localparam int LIMIT = 20000; // About seven times the expected run
    localparam int RB = 50; // Reboot allowance cycles
    logic ref_clk, arst_n = 1'b0, load_sw = 1'b0, run_sw = 1'b0, boot_done = 1'b0;
    logic card_bootable = 1'b0, card_fw_found = 1'b0, card_app_found = 1'b0;
    logic fail_mode = 1'b0, dload_active, dload_done, dload_fail;
    logic clk_en = 1'b1, self_test_pass = 1'b1, io_forcing = 1'b0; // Enable and status inputs
    logic [2:0] dload_err, fault_code = 3'h0, fail_err = 3'h3;
    logic card_boot_q, fw_load_q, app_load_q, erase_all_q, run_mode_q, reboot_q;
    logic ok_led_q, run_led_q;
    int miscompares = 0, check_count = 0, cycles = 0;
    int nfw = 0, napp = 0, ner = 0, cnt, gap; // Pulses seen, burst shape
    int nrb = 0; // Cycles of reboot request seen
    fps_front_panel #(.HOLD_CYC(HOLD), .GAP_CYC(GAP), .FLASH_CYC(FL), .REBOOT_CYC(RB))
    i_fps_front_panel (
        .ref_clk, .arst_n, .clk_en, .load_sw, .run_sw, .boot_done, .card_bootable,
        .card_fw_found, .card_app_found, .self_test_pass, .io_forcing,
        .dload_active, .dload_done, .dload_fail, .dload_err, .fault_code, .card_boot_q,
        .fw_load_q, .app_load_q, .erase_all_q, .run_mode_q, .reboot_q, .ok_led_q, .run_led_q
    );
    fps_card_model #(.LEN(20)) i_fps_card_model (
        .ref_clk, .fw_load_q, .app_load_q, .fail_mode, .fail_err,
        .dload_active, .dload_done, .dload_fail, .dload_err
    );
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Pulse tallies and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        nfw += fw_load_q;
        napp += app_load_q;
        ner += erase_all_q;
        nrb += reboot_q;
        if (cycles == LIMIT) begin
            miscompares++;
            conclude();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: level mismatch", $time);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0d wanted %0d", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Strap stays put through the synchroniser, then boot is declared
    task automatic do_reset(input logic ld);
        arst_n = 1'b0;
        boot_done = 1'b0;
        load_sw = ld;
        nfw = 0;
        step(8);
        arst_n = 1'b1;
        step(6);
        load_sw = 1'b0;
        step(120);
        boot_done = 1'b1;
    endtask
    // Hold a switch combination, release, let any download settle
    task automatic press(input logic l, input logic r, input int len);
        load_sw = l;
        run_sw = r;
        step(len);
        load_sw = 1'b0;
        run_sw = 1'b0;
        step(100);
    endtask
    // Counts one flash burst from its first rise, and the dark gap after it
    task automatic burst(output int n, output int g);
        int d;
        d = 0;
        g = 0;
        n = 1;
        while (ok_led_q !== 1'b1 && g < 300) begin
            step(1);
            g++;
        end
        while (d < GAP / 2) begin
            step(1);
            chk(run_led_q, ok_led_q);
            n += (ok_led_q === 1'b1 && d > 0);
            d = (ok_led_q === 1'b1) ? 0 : d + 1;
        end
        while (ok_led_q !== 1'b1 && d < 2 * GAP) begin
            step(1);
            d++;
        end
        g = d;
    endtask
    task automatic t_boot();
        card_bootable = 1'b1;
        card_fw_found = 1'b1;
        do_reset(1'b1);
        chk(card_boot_q, 1'b1);
        chkn(nfw, 1);
        card_bootable = 1'b0;
        do_reset(1'b1);
        chkn(nfw, 0);
        do_reset(1'b0);
        chk(card_boot_q, 1'b0);
        $display("test card boot done");
    endtask
    task automatic t_load();
        int n;
        n = 0;
        card_app_found = 1'b1;
        load_sw = 1'b1;
        while (fw_load_q !== 1'b1 && n < 2 * HOLD) begin
            step(1);
            n++;
        end
        chkn(n, HOLD + 1);
        chk(app_load_q, 1'b0);
        load_sw = 1'b0;
        step(100);
        card_fw_found = 1'b0;
        nfw = 0;
        press(1'b1, 1'b0, HOLD + 4);
        chkn(napp, 1);
        chkn(nfw, 0);
        card_app_found = 1'b0;
        press(1'b1, 1'b0, HOLD + 4);
        card_app_found = 1'b1;
        press(1'b1, 1'b0, HOLD);
        boot_done = 1'b0;
        press(1'b1, 1'b0, HOLD + 4);
        boot_done = 1'b1;
        chkn(napp + nfw, 1);
        $display("test load done");
    endtask
    task automatic t_switch();
        press(1'b0, 1'b1, HOLD + 4);
        chk(run_mode_q, 1'b1);
        chk(run_led_q, 1'b1);
        press(1'b1, 1'b1, HOLD + 4);
        chkn(ner, 1);
        chkn(napp, 1);
        chk(run_mode_q, 1'b1);
        press(1'b0, 1'b1, HOLD + 4);
        chk(run_mode_q, 1'b0);
        $display("test switch done");
    endtask
    // Self-test level, forcing flash, and a press frozen by the enable
    task automatic t_status();
        logic v;
        self_test_pass = 1'b0;
        step(2);
        chk(ok_led_q, 1'b0);
        self_test_pass = 1'b1;
        io_forcing = 1'b1;
        step(2);
        v = ok_led_q;
        step(FL);
        chk(ok_led_q, !v);
        step(FL);
        chk(ok_led_q, v);
        io_forcing = 1'b0;
        step(2);
        chk(ok_led_q, 1'b1);
        clk_en = 1'b0;
        press(1'b0, 1'b1, HOLD + 4);
        clk_en = 1'b1;
        step(2);
        chk(run_mode_q, 1'b0);
        $display("test status done");
    endtask
    task automatic t_fault();
        for (int c = 2; c <= 5; c++) begin
            fault_code = 3'(c);
            // Let the idle display give way to the dark burst start
            step(2);
            burst(cnt, gap);
            chkn(cnt, c);
            burst(cnt, gap);
            chkn(cnt, c);
            chk(gap >= GAP && gap <= GAP + FL + 1, 1'b1);
            fault_code = 3'h0;
            card_fw_found = 1'b1;
            press(1'b1, 1'b0, HOLD + 4);
        end
        $display("test fault done");
    endtask
    task automatic t_fail();
        fail_mode = 1'b1;
        load_sw = 1'b1;
        step(HOLD + 4);
        load_sw = 1'b0;
        step(30);
        burst(cnt, gap);
        burst(cnt, gap);
        chkn(cnt, 3);
        chk(gap >= GAP && gap <= GAP + FL + 1, 1'b1);
        fail_mode = 1'b0;
        nrb = 0;
        press(1'b1, 1'b0, HOLD + 4);
        chk(ok_led_q, 1'b1);
        chkn(nrb, RB);
        $display("test fail done");
    endtask
    initial begin
        t_boot();
        t_load();
        t_switch();
        t_status();
        t_fault();
        t_fail();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
